// [common/rng_health_pkg.sv]
// Constants shared by the random number health monitor and its FIFO.
// Assumes one 125 MHz clock and a synchronous active-high reset.
package rng_health_pkg;
   localparam int unsigned WORD_W = 16;
   localparam int unsigned FIFO_DEPTH = 16;
   // Start-up test window in raw bits and run limit for the stuck test
   localparam int unsigned STARTUP_BITS = 1024;
   localparam int unsigned STUCK_LIMIT = 32;
   // Online window: ones count must stay within [ONES_MIN, ONES_MAX]
   localparam int unsigned WINDOW_BITS = 256;
   localparam int unsigned ONES_MIN = 96;
   localparam int unsigned ONES_MAX = 160;
   // Entropy per bit threshold, kept for reference by software, in thousandths
   localparam int unsigned ENTROPY_MILLI = 997;
   typedef enum logic [1:0] {
      ST_OFF = 2'b00,
      ST_STARTUP = 2'b01,
      ST_RUN = 2'b11,
      ST_FAIL = 2'b10
   } state_t;
endpackage

// [logic/rng_fifo.sv]
// Holds no logic: the number buffer module sits beside the monitor in rng_health_monitor.sv.
// Kept so that all design logic stays in one file.

// [logic/rng_health_monitor.sv]
// Physical random generator health supervision and 16-bit number delivery.
// Assumes raw bits arrive synchronous to clk_in with a valid strobe.
//////////////////////////////////////////////////////////////////////////////
module rng_health_monitor #(
   parameter int unsigned WORD_W = rng_health_pkg::WORD_W,
   parameter int unsigned FIFO_DEPTH = rng_health_pkg::FIFO_DEPTH
) (
   input wire logic clk_in,
   input wire logic srst_in,
   input wire logic enable_in,
   input wire logic shutdown_in,
   input wire logic clear_flags_in,
   input wire logic raw_valid_in,
   input wire logic raw_bit_in,
   output logic num_valid_out,
   input wire logic num_ready_in,
   output logic [WORD_W-1:0] num_data_out,
   output logic running_out,
   output logic total_fail_out,
   output logic online_fail_out,
   output logic irq_out
);
   // Software reads whole sixteen-bit numbers; other widths are refused
   if (WORD_W != rng_health_pkg::WORD_W) begin
      $error("WORD_W must match the delivered number width");
   end
   localparam int unsigned SW = $clog2(rng_health_pkg::STARTUP_BITS + 1);
   localparam int unsigned WW = $clog2(rng_health_pkg::WINDOW_BITS + 1);
   localparam int unsigned RW = $clog2(rng_health_pkg::STUCK_LIMIT + 1);
   localparam int unsigned BW = $clog2(WORD_W + 1);

   // Raw bits are only tested while the generator is live
   function automatic logic is_sampling(input rng_health_pkg::state_t s);
      return s == rng_health_pkg::ST_STARTUP || s == rng_health_pkg::ST_RUN;
   endfunction

   // Only a passing run may hand numbers to software
   function automatic logic is_releasing(input rng_health_pkg::state_t s);
      return s == rng_health_pkg::ST_RUN;
   endfunction

   //////////////////////////////////////////////////////////////////////////////
   rng_health_pkg::state_t state_q, state_d;
   logic [SW-1:0] start_cnt_q, start_cnt_d;
   logic [WW-1:0] win_cnt_q, win_cnt_d, ones_q, ones_d;
   logic [RW-1:0] run_q, run_d;
   logic last_q, last_d;
   logic [WORD_W-1:0] acc_q, acc_d;
   logic [BW-1:0] nbits_q, nbits_d;
   logic tf_q, tf_d, of_q, of_d;
   logic push, fifo_ready, flush, stuck, win_end, win_bad, take;

   always_comb begin
      state_d = state_q;
      start_cnt_d = start_cnt_q;
      win_cnt_d = win_cnt_q;
      ones_d = ones_q;
      run_d = run_q;
      last_d = last_q;
      acc_d = acc_q;
      nbits_d = nbits_q;
      tf_d = tf_q;
      of_d = of_q;
      push = 1'b0;
      flush = 1'b0;
      take = raw_valid_in && is_sampling(state_q);
      // Stuck at a constant level: the total-failure criterion
      stuck = take && (raw_bit_in == last_q) && (run_q == RW'(rng_health_pkg::STUCK_LIMIT - 1));
      win_end = take && (win_cnt_q == WW'(rng_health_pkg::WINDOW_BITS - 1));
      // Bias bound is the only on-chip proxy for the entropy floor of the source
      win_bad = win_end && ((ones_q + WW'(raw_bit_in) < WW'(rng_health_pkg::ONES_MIN)) ||
                            (ones_q + WW'(raw_bit_in) > WW'(rng_health_pkg::ONES_MAX)));
      if (clear_flags_in) begin
         tf_d = 1'b0;
         of_d = 1'b0;
      end
      if (take) begin
         last_d = raw_bit_in;
         run_d = (raw_bit_in == last_q) ? run_q + RW'(1) : RW'(1);
         win_cnt_d = win_end ? '0 : win_cnt_q + WW'(1);
         ones_d = win_end ? '0 : ones_q + WW'(raw_bit_in);
      end
      case (state_q)
         rng_health_pkg::ST_OFF: begin
            if (enable_in && !shutdown_in) begin
               state_d = rng_health_pkg::ST_STARTUP;
               start_cnt_d = '0;
               win_cnt_d = '0;
               ones_d = '0;
               run_d = '0;
               nbits_d = '0;
            end
         end
         rng_health_pkg::ST_STARTUP: begin
            if (take) begin
               start_cnt_d = start_cnt_q + SW'(1);
            end
            if (take && start_cnt_q == SW'(rng_health_pkg::STARTUP_BITS - 1)) begin
               state_d = rng_health_pkg::ST_RUN;
            end
         end
         rng_health_pkg::ST_RUN: begin
            if (take) begin
               acc_d = {acc_q[WORD_W-2:0], raw_bit_in};
               nbits_d = nbits_q + BW'(1);
               // Word dropped if the FIFO is full: bits simply shift through
               if (nbits_q == BW'(WORD_W - 1)) begin
                  nbits_d = '0;
                  push = fifo_ready;
               end
            end
         end
         rng_health_pkg::ST_FAIL: begin
            if (!enable_in) begin
               state_d = rng_health_pkg::ST_OFF;
            end
         end
         default: state_d = rng_health_pkg::ST_OFF;
      endcase
      if (stuck) begin
         tf_d = 1'b1;
      end
      if (win_bad) begin
         of_d = 1'b1;
      end
      if (stuck || win_bad) begin
         // Partial word and queued words may hold failed bits, so all are dropped
         state_d = rng_health_pkg::ST_FAIL;
         push = 1'b0;
         flush = 1'b1;
         nbits_d = '0;
      end
      if (shutdown_in || !enable_in) begin
         state_d = (stuck || win_bad) ? rng_health_pkg::ST_FAIL : rng_health_pkg::ST_OFF;
         push = 1'b0;
         flush = 1'b1;
      end
   end

   always_ff @(posedge clk_in) begin
      if (srst_in) begin
         state_q <= rng_health_pkg::ST_OFF;
         start_cnt_q <= '0;
         win_cnt_q <= '0;
         ones_q <= '0;
         run_q <= '0;
         last_q <= 1'b0;
         acc_q <= '0;
         nbits_q <= '0;
         tf_q <= 1'b0;
         of_q <= 1'b0;
      end else begin
         state_q <= state_d;
         start_cnt_q <= start_cnt_d;
         win_cnt_q <= win_cnt_d;
         ones_q <= ones_d;
         run_q <= run_d;
         last_q <= last_d;
         acc_q <= acc_d;
         nbits_q <= nbits_d;
         tf_q <= tf_d;
         of_q <= of_d;
      end
   end

   //////////////////////////////////////////////////////////////////////////////
   logic fifo_valid;
   logic [WORD_W-1:0] acc_word;
   assign acc_word = {acc_q[WORD_W-2:0], raw_bit_in};

   rng_fifo #(.WIDTH(WORD_W), .DEPTH(FIFO_DEPTH)) u_fifo (
      .clk_in(clk_in),
      .srst_in(srst_in),
      .flush_in(flush),
      .in_valid_in(push),
      .in_ready_out(fifo_ready),
      .in_data_in(acc_word),
      .out_valid_out(fifo_valid),
      .out_ready_in(num_ready_in && is_releasing(state_q)),
      .out_data_out(num_data_out)
   );

   // Gate keeps numbers from leaving outside a passing run
   assign num_valid_out = fifo_valid && is_releasing(state_q);
   assign running_out = is_releasing(state_q);
   assign total_fail_out = tf_q;
   assign online_fail_out = of_q;
   assign irq_out = tf_q || of_q;
endmodule

//////////////////////////////////////////////////////////////////////////////
// Number buffer with valid/ready on both sides; flush drops all stored words in one cycle, but a word pushed in that same cycle is kept
module rng_fifo #(
   parameter int unsigned WIDTH = rng_health_pkg::WORD_W,
   parameter int unsigned DEPTH = rng_health_pkg::FIFO_DEPTH
) (
   input wire logic clk_in,
   input wire logic srst_in,
   input wire logic flush_in,
   input wire logic in_valid_in,
   output logic in_ready_out,
   input wire logic [WIDTH-1:0] in_data_in,
   output logic out_valid_out,
   input wire logic out_ready_in,
   output logic [WIDTH-1:0] out_data_out
);
   localparam int unsigned AW = $clog2(DEPTH);
   // Pointer wrap relies on a power-of-two depth
   if (DEPTH < 2 || (1 << AW) != DEPTH) begin
      $error("DEPTH must be a power of two");
   end
   logic [WIDTH-1:0] mem_q [DEPTH];
   logic [AW:0] wr_q, wr_d, rd_q, rd_d;
   logic push, pop;
   always_comb begin
      in_ready_out = (wr_q - rd_q) != (AW+1)'(DEPTH);
      out_valid_out = wr_q != rd_q;
      push = in_valid_in && in_ready_out;
      pop = out_valid_out && out_ready_in;
      wr_d = wr_q + (AW+1)'(push);
      rd_d = rd_q + (AW+1)'(pop);
      if (flush_in) begin
         rd_d = wr_q;
      end
   end
   always_ff @(posedge clk_in) begin
      if (srst_in) begin
         wr_q <= '0;
         rd_q <= '0;
      end else begin
         wr_q <= wr_d;
         rd_q <= rd_d;
      end
      if (push) begin
         mem_q[wr_q[AW-1:0]] <= in_data_in;
      end
   end
   // Memory output is a flop array read
   assign out_data_out = mem_q[rd_q[AW-1:0]];
endmodule

// [bench/rng_health_props.sv]
// Port checker for the random health monitor.
// Bound into every monitor instance; one clock.
module rng_health_props #(parameter int unsigned WORD_W = 16) (
   input wire logic clk_in,
   input wire logic srst_in,
   input wire logic enable_in,
   input wire logic shutdown_in,
   input wire logic clear_flags_in,
   input wire logic raw_valid_in,
   input wire logic raw_bit_in,
   input wire logic num_valid_out,
   input wire logic num_ready_in,
   input wire logic [WORD_W-1:0] num_data_out,
   input wire logic running_out,
   input wire logic total_fail_out,
   input wire logic online_fail_out,
   input wire logic irq_out
);
   timeunit 1ns;
   timeprecision 1ps;
   localparam int unsigned FIRST_NUM_BITS = rng_health_pkg::STARTUP_BITS + WORD_W;
   logic armed_q = 1'b0;
   logic [$clog2(FIRST_NUM_BITS + 1)-1:0] live_bits_q = '0;
   // Raw bits taken since the generator was last switched on, saturating
   always @(posedge clk_in) begin
      armed_q <= !srst_in && enable_in && !shutdown_in;
      if (srst_in || !enable_in || shutdown_in) live_bits_q <= '0;
      else if (armed_q && raw_valid_in && live_bits_q < FIRST_NUM_BITS) live_bits_q <= live_bits_q + 1'b1;
   end
   default clocking @(posedge clk_in); endclocking
   default disable iff (srst_in);
   a_valid_in_run: assert property (num_valid_out |-> running_out) else $error("valid off run");
   a_start_first: assert property (num_valid_out |-> live_bits_q >= FIRST_NUM_BITS) else $error("early");
   a_stuck_halts: assert property ($rose(total_fail_out) |-> !running_out && !num_valid_out)
      else $error("stuck");
   a_defect_halts: assert property ($rose(online_fail_out) |-> !running_out && !num_valid_out)
      else $error("defect");
   a_irq_follows: assert property (irq_out == (total_fail_out | online_fail_out)) else $error("irq");
   a_shut_stops: assert property (shutdown_in |=> !running_out) else $error("shutdown");
   a_off_idle: assert property (!enable_in |=> !running_out && !num_valid_out) else $error("off");
   a_head_holds: assert property (num_valid_out && !num_ready_in |=> !num_valid_out || $stable(num_data_out))
      else $error("head");
   a_flag_sticky: assert property (total_fail_out && !clear_flags_in |=> total_fail_out) else $error("sticky");
   a_clear_works: assert property (clear_flags_in && !raw_valid_in |=> !irq_out) else $error("clear");
endmodule
////////////////////////////////////////
bind rng_health_monitor rng_health_props #(.WORD_W(WORD_W)) props_i (.*);

// [bench/num_consumer.sv]
// Reader model: pops words with random stalls.
// hold_in forces a long stall to fill the buffer.
module num_consumer (
   input wire logic clk_in,
   input wire logic hold_in,
   output logic ready_out = 1'b0
);
   timeunit 1ns;
   timeprecision 1ps;
   int seed = 32'h42a4;
   // Takes raw words; whitening stays in software
   always @(negedge clk_in) ready_out <= !hold_in && $random(seed) % 2 != 0;
endmodule

// [bench/rng_health_monitor_tb_top.sv]
// Bench: random raw bits in, words out to a stalling reader.
// Uses the default 16-bit word, 16-deep buffer monitor.
module rng_health_monitor_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk_in = 0, srst_in = 1, enable_in = 0, shutdown_in = 0, clear_flags_in = 0, hold = 1;
   logic raw_valid_in = 0, raw_bit_in = 0, num_valid_out, num_ready_in, running_out;
   logic total_fail_out, online_fail_out, irq_out;
   logic [15:0] num_data_out, w, exp_q[$];
   int err_count = 0, samples_checked = 0, seed = 32'h42a4, i;
   rng_health_monitor uut (.*);
   num_consumer reader (.clk_in, .hold_in(hold), .ready_out(num_ready_in));
   initial forever #4 clk_in = ~clk_in;
   ////////////////////////////////////////
   always @(posedge clk_in) if ((num_valid_out & num_ready_in) === 1'b1)
      chk(num_data_out, exp_q.size() > 0 ? exp_q.pop_front() : 16'hXXXX);
   task automatic chk(input logic [15:0] s, e);
      samples_checked++;
      if (s !== e) err_count++;
      if (s !== e) $display("BAD %0t %h %h", $time, s, e);
   endtask
   task automatic wrap_up;
      $display("%0d checks %0d bad", samples_checked, err_count);
      if (err_count == 0 && samples_checked > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   task automatic send(input logic b);
      @(negedge clk_in);
      {raw_valid_in, raw_bit_in, w} = {1'b1, b, w[14:0], b};
   endtask
   task automatic idle(input int n);
      repeat (n) @(negedge clk_in) raw_valid_in = 0;
   endtask
   task automatic word(input bit q);
      repeat (16) send($random(seed) % 2 != 0);
      if (q) exp_q.push_back(w);
   endtask
   // Bounded wait for the reader to empty the buffer
   task automatic drain;
      for (i = 0; i < 500 && exp_q.size() > 0; i++) idle(1);
      idle(2);
      chk({exp_q.size() > 0, num_valid_out, online_fail_out}, 0);
      if (exp_q.size() > 0) wrap_up;
   endtask
   initial begin
      repeat (5) @(negedge clk_in);
      {srst_in, enable_in} = 2'b01;
      repeat (1023) send($random(seed) % 2 != 0);
      idle(2);
      chk(running_out, 0);
      send(0);
      idle(2);
      chk(running_out, 1);
      $display("test 1 done");
      // Reader stalled: words past the sixteenth are dropped
      repeat (20) word(exp_q.size() < 16);
      hold = 0;
      drain;
      repeat (6) word(1);
      drain;
      // Source sticks mid-run with words queued for a stalled reader
      hold = 1;
      repeat (2) word(0);
      repeat (32) send(1);
      hold = 0;
      idle(4);
      chk({total_fail_out, running_out, num_valid_out}, 3'h4);
      {enable_in, clear_flags_in} = 2'h1;
      idle(2);
      {enable_in, clear_flags_in} = 2'h2;
      // Stale words must not reappear after a fresh start-up
      repeat (1024) send($random(seed) % 2 != 0);
      idle(4);
      chk({running_out, num_valid_out}, 2'h2);
      $display("test 2 done");
      shutdown_in = 1;
      idle(2);
      chk(running_out, 0);
      {shutdown_in, enable_in} = 0;
      idle(2);
      enable_in = 1;
      $display("test 3 done");
      repeat (31) send(1);
      idle(2);
      chk(total_fail_out, 0);
      send(1);
      idle(2);
      chk({total_fail_out, irq_out, running_out, num_valid_out}, 4'hC);
      {clear_flags_in, enable_in} = 2'b10;
      idle(2);
      chk(irq_out, 0);
      {clear_flags_in, enable_in} = 2'b01;
      $display("test 4 done");
      // One in four ones: too few for a window, no long runs
      for (i = 0; i < 255; i++) send(i % 4 == 0);
      idle(2);
      chk(online_fail_out, 0);
      send(0);
      idle(2);
      chk({online_fail_out, total_fail_out, num_valid_out}, 3'h4);
      $display("test 5 done");
      wrap_up;
   end
endmodule
